//--- dv/adc_seq_properties.sv
// port-level checker for the converter sequencer, bound into adc_seq
// assumes pclk rising edge sampling and active-low asynchronous presetn
`timescale 1ns/10ps
module adc_seq_checker (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb handshake
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    // results
    input wire logic [15:0][15:0] regular_result,
    input wire logic [4:0]        regular_result_count,
    input wire logic [3:0][15:0]  injected_result_words,
    input wire logic [2:0]        injected_result_count,
    // status and events
    input wire logic              conv_busy,
    input wire logic              conv_end_pulse,
    input wire logic              injected_end_pulse
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic top_zero;
    // upper nibble of every result word must stay clear
    assign top_zero = ((regular_result & {16{16'hF000}}) == '0)
                   && ((injected_result_words & {4{16'hF000}}) == '0);
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    property p_align; top_zero; endproperty
    a_align: assert property (p_align) else $error("result not right aligned");
    property p_reg_len; regular_result_count inside {[5'd1:5'd16]}; endproperty
    a_reg_len: assert property (p_reg_len) else $error("regular count out of range");
    property p_inj_len; injected_result_count inside {[3'd1:3'd4]}; endproperty
    a_inj_len: assert property (p_inj_len) else $error("injected count out of range");
    property p_eoc_once; conv_end_pulse |=> !conv_end_pulse; endproperty
    a_eoc_once: assert property (p_eoc_once) else $error("end pulse too long");
    property p_injected_end_flag_once; injected_end_pulse |=> !injected_end_pulse; endproperty
    a_injected_end_flag_once: assert property (p_injected_end_flag_once) else $error("injected pulse too long");
    property p_eoc_busy; $rose(conv_end_pulse) |-> $past(conv_busy, 2); endproperty
    a_eoc_busy: assert property (p_eoc_busy) else $error("end pulse without run");
    property p_injected_end_flag_busy; $rose(injected_end_pulse) |-> $past(conv_busy, 2); endproperty
    a_injected_end_flag_busy: assert property (p_injected_end_flag_busy) else $error("injected pulse without run");
    property p_busy_min; $rose(conv_busy) |-> conv_busy[*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("conversion too short");
    c_eoc: cover property (conv_end_pulse);
    c_injected_end_flag: cover property (injected_end_pulse);
    c_busy: cover property ($fell(conv_busy));
endmodule // adc_seq_checker

bind adc_seq adc_seq_checker u_chk (.pclk, .presetn, .psel, .penable, .pready,
    .regular_result, .regular_result_count, .injected_result_words,
    .injected_result_count, .conv_busy, .conv_end_pulse, .injected_end_pulse);

//--- dv/adc_seq_test.sv
// self-checking bench for the converter sequencer over apb
// assumes the design, the source model and the bound checker are compiled
`timescale 1ns/10ps
module adc_seq_test import adc_seq_pkg::*; ;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
        logic        err;
    } row_s;
    // address, word written, word read back, error expected
    row_s rows [8] = '{
        '{OFS_MODE, 32'h0000_E9A0, 32'h0000_E9A0, 1'b0},
        '{OFS_SMP0, 32'h3FFF_FFFF, 32'h3FFF_FFFF, 1'b0},
        '{OFS_SMP1, 32'h00FF_FFFF, 32'h00FF_FFFF, 1'b0},
        '{OFS_SEQ2, 32'h00FF_FFFF, 32'h00FF_FFFF, 1'b0},
        '{OFS_INJ_SEQ, 32'h003F_FFFF, 32'h003F_FFFF, 1'b0},
        '{OFS_CLKDIV, 32'h0000_00FF, 32'h0000_00FF, 1'b0},
        '{OFS_REG_RES, 32'h0000_FFFF, 32'h0000_0000, 1'b0},
        '{8'h24, 32'h1234_5678, 32'h0000_0000, 1'b1}
    };
    int                hw [8] = '{3, 15, 27, 57, 83, 111, 143, 479};
    int                ins [3] = '{3, 0, 15};
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic              reg_go, inj_go, regular_trigger, injected_trigger;
    logic              conv_busy, conv_end_pulse, injected_end_pulse;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [11:0]       base;
    logic [4:0]        regular_result_count;
    logic [2:0]        injected_result_count;
    logic [15:0][11:0] analog_input;
    logic [15:0][15:0] regular_result;
    logic [3:0][15:0]  injected_result_words;
    int                n_mismatch, samples_checked, cyc, lat0, eoc_seen;

    adc_seq uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .regular_trigger, .injected_trigger, .analog_input,
        .regular_result, .regular_result_count, .injected_result_words,
        .injected_result_count, .conv_busy, .conv_end_pulse, .injected_end_pulse);
    adc_source src (.pclk, .presetn, .base, .reg_go, .inj_go, .regular_trigger,
        .injected_trigger, .analog_input);

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // expected result word for input i at a given source level
    function automatic logic [31:0] ev(input logic [11:0] b, input int i);
        return {20'h0_0000, b + 12'(i * 257)};
    endfunction
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // request one trigger pulse and set the source level
    task automatic trig(input logic inj, input logic [11:0] b);
        @(posedge pclk);
        base   <= b;
        reg_go <= !inj;
        inj_go <= inj;
        @(posedge pclk);
        reg_go <= 1'b0;
        inj_go <= 1'b0;
    endtask
    // count cycles up to the chosen end pulse
    task automatic wait_end(input logic inj);
        cyc = 0;
        do begin
            @(posedge pclk);
            #1;
            cyc++;
        end while ((inj ? injected_end_pulse : conv_end_pulse) !== 1'b1 && cyc < 2000);
        chk(32'(cyc < 2000), 32'h1);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // end-pulse counter for the gating check
    always @(posedge pclk) if (conv_end_pulse === 1'b1) eoc_seen <= eoc_seen + 1;
    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        stop_test();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, reg_go, inj_go} = 6'h00;
        {paddr, pwdata, base} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].e);
            chk(32'(err), 32'(rows[i].err));
        end
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, 32'h0);
        end
        chk(32'(regular_result_count), 32'h1);
        chk(32'(injected_result_count), 32'h1);
        apb(1'b1, OFS_MODE, 32'h0000_0020);
        apb(1'b1, OFS_SEQ0, 32'h0000_0005);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, OFS_SMP0, 32'(c) << 15);
            trig(1'b0, 12'(c * 16 + 1));
            if (c == 7) begin
                repeat (50) @(posedge pclk);
                chk(32'(conv_busy), 32'h1);
                trig(1'b0, 12'(c * 16 + 1));
            end
            wait_end(1'b0);
            if (c == 0) lat0 = cyc;
            if (c == 0) chk(32'(lat0), 32'(SMP_HALF[0]) + 32'(CONV_HALF) + 32'd2);
            chk(32'(cyc + (c == 7 ? 52 : 0)), 32'(lat0 + hw[c] - 3));
            chk(32'(regular_result[0]), ev(12'(c * 16 + 1), 5));
            #120;
            chk(32'(conv_busy), 32'h0);
        end
        apb(1'b1, OFS_SMP0, 32'h0);
        apb(1'b1, OFS_SEQ0, 32'h0000_3C03);
        apb(1'b1, OFS_SEQ2, 32'h0020_0000);
        apb(1'b1, OFS_MODE, 32'h0000_0120);
        trig(1'b0, 12'h200);
        wait_end(1'b0);
        foreach (ins[i]) chk(32'(regular_result[i]), ev(12'h200, ins[i]));
        chk(32'(regular_result_count), 32'h3);
        apb(1'b1, OFS_MODE, 32'h0000_2820);
        for (int t = 0; t < 3; t++) begin
            trig(1'b0, 12'h400 + 12'(t * 16));
            wait_end(1'b0);
        end
        chk(32'(regular_result[0]), ev(12'h420, 3));
        chk(32'(regular_result[1]), ev(12'h420, 0));
        chk(32'(regular_result[2]), ev(12'h410, 15));
        apb(1'b1, OFS_INJ_SEQ, 32'h0014_9C00);
        apb(1'b1, OFS_MODE, 32'h0000_0180);
        trig(1'b1, 12'h500);
        wait_end(1'b1);
        chk(32'(injected_result_words[2]), ev(12'h500, 7));
        chk(32'(injected_result_words[3]), ev(12'h500, 9));
        chk(32'(injected_result_words[0]), 32'h0);
        chk(32'(injected_result_count), 32'h2);
        apb(1'b1, OFS_MODE, 32'h0000_1080);
        trig(1'b1, 12'h600);
        wait_end(1'b1);
        chk(32'(injected_result_words[2]), ev(12'h600, 7));
        chk(32'(injected_result_words[3]), ev(12'h500, 9));
        apb(1'b1, OFS_MODE, 32'h0000_0580);
        apb(1'b1, OFS_STATUS, 32'h0000_0003);
        eoc_seen = 0;
        trig(1'b0, 12'h700);
        wait_end(1'b1);
        chk(32'(injected_result_words[3]), ev(12'h700, 9));
        chk(32'(eoc_seen), 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0000_0003);
        stop_test();
    end
endmodule // adc_seq_test

//--- dv/adc_source.sv
// trigger and sample source standing in front of the converter sequencer
// assumes the bench requests trigger pulses right after pclk rising edges
`timescale 1ns/10ps
module adc_source (
    // clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    // bench requests
    input wire logic [11:0]   base,
    input wire logic          reg_go,
    input wire logic          inj_go,
    // towards the converter
    output logic              regular_trigger,
    output logic              injected_trigger,
    output logic [15:0][11:0] analog_input
);
    // one-cycle trigger pulses on dedicated lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regular_trigger  <= 1'b0;
            injected_trigger <= 1'b0;
        end else begin
            regular_trigger  <= reg_go;
            injected_trigger <= inj_go;
        end
    end
    // every input carries its own level so a wrong selection shows
    always_comb begin
        for (int i = 0; i < 16; i++) analog_input[i] = base + 12'(i * 257);
    end
endmodule // adc_source

//--- src/adc_seq.sv
// sequencer and control for a 12-bit converter with regular and injected groups
// assumes apb master on pclk, trigger inputs and sample values synchronous to pclk
//
// Overview of operation
// - convert selected inputs at 12-bit resolution
// - all timing counted in half converter clock periods
// - dedicated regular and injected trigger inputs only
// - no continuous mode; each run needs trigger
// - sixteen separate 16-bit regular results
// - four injected result words available
// - result count follows configured sequence length
// - results always right aligned
// - regular burst converts burst count plus one
// - injected discontinuous enable steps injected group
// - regular discontinuous enable makes regular bursts
// - auto injection runs injected after regular group
// - scan converts whole group per trigger
// - single mode converts one entry per trigger
// - 3-bit code picks per-input sampling time
// - sample codes of inputs 16, 17 ignored
// - sixteen regular and four injected entries
// - busy output high during a conversion
// - end of conversion pulse outputs
// - no analog watchdog logic
// - short injected sequence uses last slots
// - wrap to first entry, await next trigger
// - low four entry bits select input
// - end flags set, pulses gated by enables
`timescale 1ns/10ps

module adc_seq
    import adc_seq_pkg::*;
#(
    parameter logic [7:0] CLKDIV_DEFAULT = RST_CLKDIV
) (
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // triggers and sample inputs
    input  wire logic                regular_trigger,
    input  wire logic                injected_trigger,
    input  wire logic [15:0][11:0]   analog_input,
    // results
    output logic [15:0][15:0]        regular_result,
    output logic [4:0]               regular_result_count,
    output logic [3:0][15:0]         injected_result_words,
    output logic [2:0]               injected_result_count,
    // status and events
    output logic                     conv_busy,
    output logic                     conv_end_pulse,
    output logic                     injected_end_pulse
);

    // register storage
    // every register below resets to zero except the divider, which takes its default
    logic [31:0]       mode_q, smp0_q, smp1_q, seq0_q, seq1_q, seq2_q, inj_seq_q;
    logic [7:0]        div_q;
    logic              eoc_flag_q, injected_end_flag_flag_q;
    logic [15:0][15:0] reg_res_q;
    logic [3:0][15:0]  inj_res_q;
    logic [31:0]       rdata_q;
    logic              err_q;

    // sequencer state
    conv_state_e       state_q;
    logic [7:0]        div_cnt_q;
    logic              half_tick;
    logic [8:0]        cnt_q;
    logic              grp_inj_q;
    logic [3:0]        chan_q;
    logic [11:0]       sample_q;
    logic              reg_run_q, inj_run_q;
    logic [3:0]        reg_pos_q, reg_left_q;
    logic [1:0]        inj_pos_q, inj_left_q;
    logic              eoc_pulse_q, injected_end_flag_pulse_q;

    // decoded fields
    logic [3:0]        reg_len;
    logic [1:0]        inj_len;
    logic [79:0]       reg_entries;
    logic [47:0]       smp_all;
    logic              wr_en, rd_setup;
    logic              done_evt, reg_wrap, inj_wrap, reg_end, inj_end;
    logic              reg_accept, inj_accept, auto_start;
    logic [1:0]        inj_slot;
    logic [4:0]        pick_entry;
    logic [3:0]        pick_chan;
    logic [2:0]        pick_code;
    logic              start_inj, start_reg;

    assign reg_len     = seq2_q[POS_REG_LEN +: 4];
    assign inj_len     = inj_seq_q[POS_INJ_LEN +: 2];
    assign reg_entries = {seq2_q[19:0], seq1_q[29:0], seq0_q[29:0]};
    assign smp_all     = {smp1_q[17:0], smp0_q[29:0]};

    // apb handshake: zero wait states, data loaded in setup phase
    // pready simply follows penable, so no transfer can stall the bus;
    // read data and the error flag are registered one edge earlier
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign pready   = penable;
    assign prdata   = rdata_q;
    assign pslverr  = err_q;

    // read mux and unmapped address check, captured in setup phase
    // the status word holds the end flags and busy only, no watchdog state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= RST_ZERO;
            err_q   <= 1'b0;
        end else if (rd_setup) begin
            err_q   <= 1'b0;
            rdata_q <= RST_ZERO;
            if (paddr[1:0] != 2'b00) begin
                err_q <= 1'b1;
            end else if (paddr >= OFS_INJ_RES && paddr < OFS_INJ_RES + 8'h10) begin
                rdata_q <= {16'h0000, inj_res_q[paddr[3:2]]};
            end else if (paddr >= OFS_REG_RES && paddr < OFS_REG_RES + 8'h40) begin
                rdata_q <= {16'h0000, reg_res_q[paddr[5:2]]};
            end else begin
                case (paddr)
                    OFS_MODE:    rdata_q <= mode_q;
                    OFS_SMP0:    rdata_q <= smp0_q;
                    OFS_SMP1:    rdata_q <= smp1_q;
                    OFS_SEQ0:    rdata_q <= seq0_q;
                    OFS_SEQ1:    rdata_q <= seq1_q;
                    OFS_SEQ2:    rdata_q <= seq2_q;
                    OFS_INJ_SEQ: rdata_q <= inj_seq_q;
                    OFS_CLKDIV:  rdata_q <= {24'h00_0000, div_q};
                    OFS_STATUS:  rdata_q <= {29'h0000_0000, conv_busy, injected_end_flag_flag_q, eoc_flag_q};
                    default:     err_q   <= 1'b1;
                endcase
            end
        end
    end

    // configuration registers
    // result and status words are not writable here; status clears below
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q    <= RST_ZERO;
            smp0_q    <= RST_ZERO;
            smp1_q    <= RST_ZERO;
            seq0_q    <= RST_ZERO;
            seq1_q    <= RST_ZERO;
            seq2_q    <= RST_ZERO;
            inj_seq_q <= RST_ZERO;
            div_q     <= CLKDIV_DEFAULT;
        end else if (wr_en) begin
            case (paddr)
                OFS_MODE:    mode_q    <= pwdata;
                OFS_SMP0:    smp0_q    <= pwdata;
                OFS_SMP1:    smp1_q    <= pwdata;
                OFS_SEQ0:    seq0_q    <= pwdata;
                OFS_SEQ1:    seq1_q    <= pwdata;
                OFS_SEQ2:    seq2_q    <= pwdata;
                OFS_INJ_SEQ: inj_seq_q <= pwdata;
                OFS_CLKDIV:  div_q     <= pwdata[7:0];
                default:     ;
            endcase
        end
    end

    // sticky end flags, write one to clear, a new event wins over the clear
    // so software never loses an end that lands on the clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eoc_flag_q  <= 1'b0;
            injected_end_flag_flag_q <= 1'b0;
        end else begin
            if (reg_end || inj_end) begin
                eoc_flag_q <= 1'b1;
            end else if (wr_en && paddr == OFS_STATUS && pwdata[BIT_ST_EOC]) begin
                eoc_flag_q <= 1'b0;
            end
            if (inj_end) begin
                injected_end_flag_flag_q <= 1'b1;
            end else if (wr_en && paddr == OFS_STATUS && pwdata[BIT_ST_INJECTED_END_FLAG]) begin
                injected_end_flag_flag_q <= 1'b0;
            end
        end
    end

    // converter time base: one tick per half converter clock period
    // a divider of zero gives a half tick on every pclk cycle, the fastest rate;
    // changing the divider mid conversion stretches or shortens the tick in progress and those that follow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 8'h00;
        end else if (div_cnt_q >= div_q) begin
            div_cnt_q <= 8'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end
    assign half_tick = (div_cnt_q >= div_q);

    // entry selection for the next conversion
    // injected slots count back from the last one, so a short group uses the end
    assign inj_slot   = 2'(2'd3 - inj_len + inj_pos_q);
    assign start_inj  = (state_q == ST_IDLE) && inj_run_q;
    assign start_reg  = (state_q == ST_IDLE) && !inj_run_q && reg_run_q;
    always_comb begin
        if (inj_run_q) begin
            pick_entry = inj_seq_q[inj_slot*ENTRY_W +: ENTRY_W];
        end else begin
            pick_entry = reg_entries[reg_pos_q*ENTRY_W +: ENTRY_W];
        end
    end
    assign pick_chan = pick_entry[3:0];
    assign pick_code = smp_all[pick_chan*3 +: 3];

    // completion decode
    // a run ends at the sequence end or when its entry budget runs out;
    // a budget of zero means no limit other than the sequence end
    assign done_evt = (state_q == ST_CONV) && half_tick && (cnt_q == 9'h001);
    assign reg_wrap = (reg_pos_q == reg_len);
    assign inj_wrap = (inj_pos_q == inj_len);
    assign reg_end  = done_evt && !grp_inj_q && (reg_wrap || reg_left_q == 4'h1);
    assign inj_end  = done_evt && grp_inj_q && (inj_wrap || inj_left_q == 2'h1);
    assign auto_start = done_evt && !grp_inj_q && reg_wrap && mode_q[BIT_AUTO];

    // trigger acceptance; a trigger to a running group is dropped
    // a trigger held high starts a new run as soon as the current one ends
    assign reg_accept = regular_trigger && !reg_run_q;
    assign inj_accept = injected_trigger && !inj_run_q;

    // conversion engine: sampling window then fixed conversion time
    // the input is captured on the last sampling tick and held while the
    // fixed conversion time runs, so later input changes cannot leak in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= ST_IDLE;
            cnt_q     <= 9'h000;
            grp_inj_q <= 1'b0;
            chan_q    <= 4'h0;
            sample_q  <= 12'h000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_inj || start_reg) begin
                        state_q   <= ST_SAMPLE;
                        grp_inj_q <= start_inj;
                        chan_q    <= pick_chan;
                        cnt_q     <= SMP_HALF[pick_code];
                    end
                end
                ST_SAMPLE: begin
                    if (half_tick) begin
                        if (cnt_q == 9'h001) begin
                            state_q  <= ST_CONV;
                            sample_q <= analog_input[chan_q];
                            cnt_q    <= CONV_HALF;
                        end else begin
                            cnt_q <= cnt_q - 9'h001;
                        end
                    end
                end
                ST_CONV: begin
                    if (half_tick) begin
                        if (cnt_q == 9'h001) begin
                            state_q <= ST_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 9'h001;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    assign conv_busy = (state_q != ST_IDLE);

    // regular group progress: single, scan and burst runs
    // position survives between triggers so bursts walk through the group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_run_q  <= 1'b0;
            reg_pos_q  <= 4'h0;
            reg_left_q <= 4'h0;
        end else if (reg_accept) begin
            reg_run_q <= 1'b1;
            if (mode_q[BIT_REG_DISC]) begin
                reg_left_q <= {1'b0, mode_q[POS_BURST +: 3]} + 4'h1;
            end else if (mode_q[BIT_SCAN]) begin
                reg_left_q <= 4'h0;
            end else begin
                reg_left_q <= 4'h1;
            end
        end else if (done_evt && !grp_inj_q) begin
            reg_pos_q  <= reg_wrap ? 4'h0 : reg_pos_q + 4'h1;
            reg_left_q <= reg_left_q - 4'h1;
            if (reg_end) begin
                reg_run_q <= 1'b0;
            end
        end
    end

    // injected group progress, also started by auto injection
    // auto injection wins over a trigger in the same cycle and runs the
    // whole injected group whatever the scan setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inj_run_q  <= 1'b0;
            inj_pos_q  <= 2'h0;
            inj_left_q <= 2'h0;
        end else if (auto_start) begin
            inj_run_q  <= 1'b1;
            inj_left_q <= 2'h0;
        end else if (inj_accept) begin
            inj_run_q <= 1'b1;
            if (mode_q[BIT_INJ_DISC] || !mode_q[BIT_SCAN]) begin
                inj_left_q <= 2'h1;
            end else begin
                inj_left_q <= 2'h0;
            end
        end else if (done_evt && grp_inj_q) begin
            inj_pos_q  <= inj_wrap ? 2'h0 : inj_pos_q + 2'h1;
            inj_left_q <= inj_left_q - 2'h1;
            if (inj_end) begin
                inj_run_q <= 1'b0;
            end
        end
    end

    // result words, right aligned 12-bit codes
    // the top four bits always stay clear, there is no left aligned format
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_res_q <= '0;
            inj_res_q <= '0;
        end else if (done_evt) begin
            if (grp_inj_q) begin
                inj_res_q[inj_slot] <= {4'h0, sample_q};
            end else begin
                reg_res_q[reg_pos_q] <= {4'h0, sample_q};
            end
        end
    end

    // end pulses gated by enables
    // pulses follow the done edge by one cycle; the flags are never gated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eoc_pulse_q  <= 1'b0;
            injected_end_flag_pulse_q <= 1'b0;
        end else begin
            eoc_pulse_q  <= (reg_end || inj_end) && mode_q[BIT_EOC_IE];
            injected_end_flag_pulse_q <= inj_end && mode_q[BIT_INJECTED_END_FLAG_IE];
        end
    end

    // output ports
    // the counts tell the consumer how many result words are meaningful
    assign regular_result        = reg_res_q;
    assign injected_result_words = inj_res_q;
    assign regular_result_count  = {1'b0, reg_len} + 5'h01;
    assign injected_result_count = {1'b0, inj_len} + 3'h1;
    assign conv_end_pulse        = eoc_pulse_q;
    assign injected_end_pulse    = injected_end_flag_pulse_q;

endmodule // adc_seq

//--- src/adc_seq_pkg.sv
// constants for the converter sequencer: register map, field layout, timing
// assumes a 32-bit apb register port and a 16-input sample source
package adc_seq_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_SMP0     = 8'h04;
    localparam logic [7:0] OFS_SMP1     = 8'h08;
    localparam logic [7:0] OFS_SEQ0     = 8'h0C;
    localparam logic [7:0] OFS_SEQ1     = 8'h10;
    localparam logic [7:0] OFS_SEQ2     = 8'h14;
    localparam logic [7:0] OFS_INJ_SEQ  = 8'h18;
    localparam logic [7:0] OFS_CLKDIV   = 8'h1C;
    localparam logic [7:0] OFS_STATUS   = 8'h20;
    localparam logic [7:0] OFS_REG_RES  = 8'h40;
    localparam logic [7:0] OFS_INJ_RES  = 8'h80;

    // mode control field positions
    localparam int BIT_EOC_IE   = 5;
    localparam int BIT_INJECTED_END_FLAG_IE  = 7;
    localparam int BIT_SCAN     = 8;
    localparam int BIT_AUTO     = 10;
    localparam int BIT_REG_DISC = 11;
    localparam int BIT_INJ_DISC = 12;
    localparam int POS_BURST    = 13;

    // sequence config layout
    localparam int ENTRY_W      = 5;
    localparam int POS_REG_LEN  = 20;
    localparam int POS_INJ_LEN  = 20;

    // status bits
    localparam int BIT_ST_EOC   = 0;
    localparam int BIT_ST_INJECTED_END_FLAG  = 1;
    localparam int BIT_ST_BUSY  = 2;

    // reset values
    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
    localparam logic [7:0]  RST_CLKDIV = 8'h00;

    // timing in half converter clock periods
    localparam logic [8:0] CONV_HALF = 9'h019; // fixed 12.5 cycles
    localparam logic [8:0] SMP_HALF [8] = '{
        9'h003, 9'h00F, 9'h01B, 9'h039, 9'h053, 9'h06F, 9'h08F, 9'h1DF
    };

    // converter engine states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10
    } conv_state_e;

endpackage
